// [hdl/adcrc_pkg.sv]
// Package for the converter register control block.
// Assumes an 8-bit CPU bus with byte offsets relative to the block base.
package adcrc_pkg;
   // Byte offsets of the register map
   localparam logic [4:0] ADCRC_OFS_RES0 = 5'h00; // Result regs, module 0
   localparam logic [4:0] ADCRC_OFS_RES1 = 5'h08; // Result regs, module 1
   localparam logic [4:0] ADCRC_OFS_CSR0 = 5'h10; // Control/status, mod 0
   localparam logic [4:0] ADCRC_OFS_CSR1 = 5'h11; // Control/status, mod 1
   localparam logic [4:0] ADCRC_OFS_TRG0 = 5'h12; // Trigger control, mod 0
   localparam logic [4:0] ADCRC_OFS_TRG1 = 5'h13; // Trigger control, mod 1
   // Control/status and trigger control field positions
   localparam int ADCRC_CSR_END = 7;
   localparam int ADCRC_CSR_IE = 6;
   localparam int ADCRC_CSR_ST = 5;
   localparam int ADCRC_CSR_SCAN = 4;
   localparam int ADCRC_CSR_SPD = 3;
   localparam int ADCRC_CSR_RSV = 2;
   localparam int ADCRC_TRG_EN = 7;
   // Values after reset
   localparam logic [15:0] ADCRC_RES_RST = 16'h0000;
   localparam logic [7:0] ADCRC_CSR_RST = 8'h00;
   localparam logic [7:0] ADCRC_TRG_RST = 8'h7f;
   localparam logic [6:0] ADCRC_TRG_ONES = 7'h7f;
   // Conversion times in states (one state is one clock)
   localparam int ADCRC_CONV_SLOW = 266;
   localparam int ADCRC_CONV_FAST = 134;
   localparam logic [8:0] ADCRC_CNT_SLOW = 9'(ADCRC_CONV_SLOW - 1);
   localparam logic [8:0] ADCRC_CNT_FAST = 9'(ADCRC_CONV_FAST - 1);
endpackage

// [hdl/adcrc_unit.sv]
// One converter module: control/status, trigger control, four results.
// Assumes the analog core hands back a 10-bit sample on demand.
`timescale 1ns/1ps
module adcrc_unit
   import adcrc_pkg::*;
#(
   parameter int RES_W = 10
)
(
   input wire logic clk,
   input wire logic rst,
   input wire logic standby,
   input wire logic csr_wr,
   input wire logic trg_wr,
   input wire logic [7:0] wdata,
   input wire logic csr_rd,
   input wire logic xfer_clr,
   input wire logic trig_start,
   input wire logic [RES_W-1:0] sample,
   output logic [7:0] csr_q,
   output logic trg_en_q,
   output logic [1:0] chan_q,
   output logic [RES_W-1:0] res_q [4],
   output logic irq
);
   // Converter sequencing states
   typedef enum logic {ADCRC_IDLE, ADCRC_CONV} adcrc_state_t;
   adcrc_state_t state_q; // Current sequencing state
   logic [8:0] cnt_q; // Cycles left in current conversion
   logic end_seen_q; // Flag was read as one since last set
   logic done; // Current channel finished
   logic last; // Current channel ends the scan group
   logic [1:0] first_ch; // Channel a run starts with
   logic clr_wr; // Legal software clear of the flag
   // Initialisation: power-on reset or standby
   logic init;
   assign init = rst | standby;

   assign done = (state_q == ADCRC_CONV) && (cnt_q == 9'h000);
   // Scan group grows from the first input to the code
   assign last = csr_q[ADCRC_CSR_SCAN] ? (chan_q == csr_q[1:0]) : 1'b1;
   assign first_ch = csr_q[ADCRC_CSR_SCAN] ? 2'h0 : csr_q[1:0];
   assign clr_wr = csr_wr && !wdata[ADCRC_CSR_END] && end_seen_q;
   // Interrupt request follows the gated flag
   assign irq = csr_q[ADCRC_CSR_END] & csr_q[ADCRC_CSR_IE];

   // Control/status register
   always_ff @(posedge clk)
   begin
      if (init)
      begin
         csr_q <= ADCRC_CSR_RST;
      end
      else
      begin
         if (csr_wr)
         begin
            // Bit 2 kept at zero; flag bit not writable here
            csr_q[6:3] <= wdata[6:3];
            csr_q[ADCRC_CSR_RSV] <= 1'b0;
            csr_q[1:0] <= wdata[1:0];
         end
         // Trigger sets start, winning over a same-cycle write
         if (trig_start)
         begin
            csr_q[ADCRC_CSR_ST] <= 1'b1;
         end
         else if (done && !csr_q[ADCRC_CSR_SCAN] && !csr_wr)
         begin
            csr_q[ADCRC_CSR_ST] <= 1'b0;
         end
         // Flag: set wins over any clear
         if (done && last && csr_q[ADCRC_CSR_ST])
         begin
            csr_q[ADCRC_CSR_END] <= 1'b1;
         end
         else if (clr_wr || xfer_clr)
         begin
            csr_q[ADCRC_CSR_END] <= 1'b0;
         end
      end
   end

   // Read-as-one tracker for the flag clear handshake
   always_ff @(posedge clk)
   begin
      if (init)
      begin
         end_seen_q <= 1'b0;
      end
      else if (done && last)
      begin
         end_seen_q <= 1'b0; // New set needs a new read
      end
      else if (csr_rd && csr_q[ADCRC_CSR_END])
      begin
         end_seen_q <= 1'b1;
      end
      else if (clr_wr)
      begin
         end_seen_q <= 1'b0;
      end
   end

   // Trigger control register: only enable bit is stored
   always_ff @(posedge clk)
   begin
      if (init)
      begin
         trg_en_q <= ADCRC_TRG_RST[ADCRC_TRG_EN];
      end
      else if (trg_wr)
      begin
         trg_en_q <= wdata[ADCRC_TRG_EN];
      end
   end

   // Sequencer: counts one conversion time per channel
   always_ff @(posedge clk)
   begin
      if (init)
      begin
         state_q <= ADCRC_IDLE;
         cnt_q <= 9'h000;
         chan_q <= 2'h0;
      end
      else
      begin
         case (state_q)
            ADCRC_IDLE:
            begin
               if (csr_q[ADCRC_CSR_ST])
               begin
                  state_q <= ADCRC_CONV;
                  chan_q <= first_ch;
                  cnt_q <= csr_q[ADCRC_CSR_SPD] ? ADCRC_CNT_FAST
                                                : ADCRC_CNT_SLOW;
               end
            end
            default:
            begin
               if (!csr_q[ADCRC_CSR_ST])
               begin
                  state_q <= ADCRC_IDLE; // Abort at once
               end
               else if (done)
               begin
                  if (csr_q[ADCRC_CSR_SCAN])
                  begin
                     // Wrap to the first input and keep going
                     chan_q <= last ? 2'h0 : chan_q + 2'h1;
                     cnt_q <= csr_q[ADCRC_CSR_SPD] ? ADCRC_CNT_FAST
                                                   : ADCRC_CNT_SLOW;
                  end
                  else
                  begin
                     state_q <= ADCRC_IDLE;
                  end
               end
               else
               begin
                  cnt_q <= cnt_q - 9'h001;
               end
            end
         endcase
      end
   end

   // Result registers, one per input in channel order
   genvar g;
   generate
      for (g = 0; g < 4; g++)
      begin : g_res
         always_ff @(posedge clk)
         begin
            if (init)
            begin
               res_q[g] <= ADCRC_RES_RST[RES_W-1:0];
            end
            else if (done && csr_q[ADCRC_CSR_ST] && chan_q == 2'(g))
            begin
               res_q[g] <= sample;
            end
         end
      end
   endgenerate
endmodule

// [hdl/adcrc_top.sv]
// Top of the converter register control: two modules, CPU byte port.
// Assumes a single-cycle 8-bit CPU bus; manual reset is simply not wired.
`timescale 1ns/1ps
// Operation
// - Result high byte top eight, bits 7:6 low
// - Low byte bits 5:0 read zero
// - Results cleared by reset or standby
// - Control/status cleared by reset or standby
// - Flag set at single end or scan group end
// - Flag cleared by zero write after reading one
// - Transfer access clears flag automatically
// - Interrupt enable gates request, resets zero
// - Single mode start bit self-clears at end
// - Scan repeats while start bit stays one
// - External trigger may also set start
// - Speed bit picks 266 or 134 states
// - Control bit 2 reads zero, write zero
// - Channel field decoded with mode bit
// - Trigger control resets to 0x7f
// - Enabled triggers start on final edge
// - Shared triggers, enables combined by OR
// - Trigger control low seven bits read one
// - High read returns byte, latches low byte
// - Interrupt when flag set and enabled
// - Each input has matching result register
module adcrc_top
   import adcrc_pkg::*;
#(
   parameter int RES_W = 10
)
(
   input wire logic CLK,
   input wire logic RST,
   input wire logic STANDBY,
   input wire logic [4:0] ADDR,
   input wire logic RD,
   input wire logic WR,
   input wire logic [7:0] WDATA,
   output logic [7:0] RDATA,
   input wire logic XFER_ACC0,
   input wire logic XFER_ACC1,
   input wire logic EXT_TRIGGER_PIN_N,
   input wire logic TIMER_UNIT_TRIGGER,
   input wire logic [RES_W-1:0] SAMPLE0,
   input wire logic [RES_W-1:0] SAMPLE1,
   output logic [1:0] CHAN0,
   output logic [1:0] CHAN1,
   output logic CONV_DONE_IRQ0,
   output logic CONV_DONE_IRQ1
);
   logic [7:0] csr [2]; // Control/status per module
   logic trg_en [2]; // Trigger enable per module
   logic [RES_W-1:0] res [2][4]; // Results per module
   logic [RES_W-1:0] samp [2]; // Samples per module
   logic xacc [2]; // Transfer-controller accesses
   logic [1:0] chan [2]; // Channel under conversion
   logic irq [2]; // Interrupt request per module
   logic pin_q; // Previous trigger pin level
   logic trig_any; // Enabled trigger event
   logic [1:0] temp_q; // Latched low result bits
   logic [7:0] rdata_d; // Next read data

   assign samp[0] = SAMPLE0;
   assign samp[1] = SAMPLE1;
   assign xacc[0] = XFER_ACC0;
   assign xacc[1] = XFER_ACC1;
   assign CHAN0 = chan[0];
   assign CHAN1 = chan[1];
   assign CONV_DONE_IRQ0 = irq[0];
   assign CONV_DONE_IRQ1 = irq[1];

   // Pin history for the falling (final) edge
   always_ff @(posedge CLK)
   begin
      if (RST)
      begin
         pin_q <= 1'b1;
      end
      else
      begin
         pin_q <= EXT_TRIGGER_PIN_N;
      end
   end

   // Shared triggers, gated by OR of both enables
   assign trig_any = (trg_en[0] | trg_en[1]) &
      ((pin_q & ~EXT_TRIGGER_PIN_N) | TIMER_UNIT_TRIGGER);

   // Two converter modules, same trigger feed
   genvar m;
   generate
      for (m = 0; m < 2; m++)
      begin : g_mod
         adcrc_unit #(.RES_W(RES_W)) u_unit (
            .clk(CLK),
            .rst(RST),
            .standby(STANDBY),
            .csr_wr(WR && ADDR == (m == 0 ? ADCRC_OFS_CSR0 : ADCRC_OFS_CSR1)),
            .trg_wr(WR && ADDR == (m == 0 ? ADCRC_OFS_TRG0 : ADCRC_OFS_TRG1)),
            .wdata(WDATA),
            .csr_rd(RD && ADDR == (m == 0 ? ADCRC_OFS_CSR0 : ADCRC_OFS_CSR1)),
            .xfer_clr(xacc[m]),
            .trig_start(trig_any),
            .sample(samp[m]),
            .csr_q(csr[m]),
            .trg_en_q(trg_en[m]),
            .chan_q(chan[m]),
            .res_q(res[m]),
            .irq(irq[m])
         );
      end
   endgenerate

   // Read decode; low result bytes come from the latch
   always_comb
   begin
      rdata_d = 8'h00;
      if (ADDR < ADCRC_OFS_CSR0)
      begin
         if (!ADDR[0])
         begin
            rdata_d = res[ADDR[3]][ADDR[2:1]][RES_W-1:RES_W-8];
         end
         else
         begin
            rdata_d = {temp_q, 6'h00};
         end
      end
      else if (ADDR == ADCRC_OFS_CSR0)
      begin
         rdata_d = csr[0];
      end
      else if (ADDR == ADCRC_OFS_CSR1)
      begin
         rdata_d = csr[1];
      end
      else if (ADDR == ADCRC_OFS_TRG0)
      begin
         rdata_d = {trg_en[0], ADCRC_TRG_ONES};
      end
      else if (ADDR == ADCRC_OFS_TRG1)
      begin
         rdata_d = {trg_en[1], ADCRC_TRG_ONES};
      end
   end

   // High-byte read snapshots the low bits; order is the CPU's duty
   always_ff @(posedge CLK)
   begin
      if (RST)
      begin
         temp_q <= 2'h0;
      end
      else if (RD && ADDR < ADCRC_OFS_CSR0 && !ADDR[0])
      begin
         temp_q <= res[ADDR[3]][ADDR[2:1]][1:0];
      end
   end

   // Registered read data, one cycle after the strobe
   always_ff @(posedge CLK)
   begin
      if (RST)
      begin
         RDATA <= 8'h00;
      end
      else if (RD)
      begin
         RDATA <= rdata_d;
      end
   end
endmodule

// [tb/adcrc_core_model.sv]
// Behavioural analog core for the two converter modules.
// Assumes the channel outputs are settled when a conversion ends.
`timescale 1ns/1ps
module adcrc_core_model (
   input wire logic [1:0] chan0,
   input wire logic [1:0] chan1,
   output logic [9:0] sample0,
   output logic [9:0] sample1
);
   // Channel shows in the top bits, so a misfiled result is seen
   assign sample0 = {chan0, 8'h5a};
   assign sample1 = {chan1, 8'ha6};
endmodule

// [tb/adcrc_checker.sv]
// Port checks for the converter register control top.
// Assumes the byte map of the package and single-cycle strobes.
`timescale 1ns/1ps
module adcrc_checker (
   input wire logic CLK,
   input wire logic RST,
   input wire logic STANDBY,
   input wire logic [4:0] ADDR,
   input wire logic RD,
   input wire logic WR,
   input wire logic [7:0] WDATA,
   input wire logic [7:0] RDATA,
   input wire logic XFER_ACC0,
   input wire logic CONV_DONE_IRQ0,
   input wire logic CONV_DONE_IRQ1
);
   // One domain, so clock and reset are given once
   default clocking cb @(posedge CLK); endclocking
   default disable iff (RST);
   a_low_zero:
   assert property (RD && !ADDR[4] && ADDR[0] |=> RDATA[5:0] == 6'h00)
      else $error("low byte spare bits not zero");
   a_trg_ones:
   assert property (RD && ADDR[4:1] == 4'h9 |=> RDATA[6:0] == 7'h7f)
      else $error("trigger control low bits not one");
   a_rsv_zero:
   assert property (RD && ADDR[4:1] == 4'h8 |=> !RDATA[2])
      else $error("control bit 2 not zero");
   a_rdata_holds:
   assert property (!RD && !STANDBY |=> $stable(RDATA))
      else $error("read data moved without a read");
   a_xfer_clears:
   assert property (XFER_ACC0 |=> !CONV_DONE_IRQ0)
      else $error("transfer access left request up");
   a_standby_clears:
   assert property (STANDBY |=> !CONV_DONE_IRQ0 && !CONV_DONE_IRQ1)
      else $error("standby left request up");
   a_one_write_kept:
   assert property (WR && ADDR == 5'h10 && WDATA[7:6] == 2'h3 &&
      CONV_DONE_IRQ0 && !XFER_ACC0 && !STANDBY |=> CONV_DONE_IRQ0)
      else $error("writing one changed the flag");
   a_enable_gates:
   assert property (WR && ADDR == 5'h10 && !WDATA[6] |=> !CONV_DONE_IRQ0)
      else $error("request up while disabled");
   // Main scenarios reached
   c_irq0: cover property ($rose(CONV_DONE_IRQ0));
   c_irq1: cover property ($rose(CONV_DONE_IRQ1));
   c_xfer: cover property (XFER_ACC0 && CONV_DONE_IRQ0);
endmodule
bind adcrc_top adcrc_checker u_adcrc_checker (
   .CLK(CLK), .RST(RST), .STANDBY(STANDBY), .ADDR(ADDR), .RD(RD),
   .WR(WR), .WDATA(WDATA), .RDATA(RDATA), .XFER_ACC0(XFER_ACC0),
   .CONV_DONE_IRQ0(CONV_DONE_IRQ0), .CONV_DONE_IRQ1(CONV_DONE_IRQ1)
);

// [tb/test_adc_register_control.sv]
// Self-checking bench for the converter register control.
// Assumes the core model and checker files are compiled first.
`timescale 1ns/1ps
module test_adc_register_control;
   logic CLK = 0, RST = 1, STANDBY = 0, RD = 0, WR = 0;
   logic XFER_ACC0 = 0, EXT_TRIGGER_PIN_N = 1, TIMER_UNIT_TRIGGER = 0;
   logic XFER_ACC1 = 0;
   logic [4:0] ADDR = 5'h00;
   logic [7:0] WDATA = 8'h00, RDATA;
   logic [9:0] SAMPLE0, SAMPLE1;
   logic [1:0] CHAN0, CHAN1;
   logic CONV_DONE_IRQ0, CONV_DONE_IRQ1;
   int fails = 0, tests_run = 0, cyc = 0, n_slow, n_fast;
   always #5 CLK = ~CLK;
   adcrc_top u_adcrc_top (.CLK(CLK), .RST(RST), .STANDBY(STANDBY),
      .ADDR(ADDR), .RD(RD), .WR(WR), .WDATA(WDATA), .RDATA(RDATA),
      .XFER_ACC0(XFER_ACC0), .XFER_ACC1(XFER_ACC1),
      .EXT_TRIGGER_PIN_N(EXT_TRIGGER_PIN_N),
      .TIMER_UNIT_TRIGGER(TIMER_UNIT_TRIGGER), .SAMPLE0(SAMPLE0),
      .SAMPLE1(SAMPLE1), .CHAN0(CHAN0), .CHAN1(CHAN1),
      .CONV_DONE_IRQ0(CONV_DONE_IRQ0), .CONV_DONE_IRQ1(CONV_DONE_IRQ1));
   adcrc_core_model u_adcrc_core_model (.chan0(CHAN0), .chan1(CHAN1),
      .sample0(SAMPLE0), .sample1(SAMPLE1));
   task automatic conclude;
      if (fails == 0 && tests_run > 0)
         $display("Regression OK");
      else
         $display("Regression broken");
      $finish;
   endtask
   task automatic chk(input string n, input logic [7:0] e, g);
      tests_run++;
      if (g !== e)
      begin
         fails++;
         $display("wrong value %s exp %h got %h", n, e, g);
      end
   endtask
   // Bus strobes last one cycle, driven on the falling edge
   task automatic wr(input logic [4:0] a, input logic [7:0] d);
      @(negedge CLK);
      ADDR = a;
      WDATA = d;
      WR = 1;
      @(negedge CLK);
      WR = 0;
   endtask
   task automatic rdchk(input logic [4:0] a, input logic [7:0] e,
      input string n);
      @(negedge CLK);
      ADDR = a;
      RD = 1;
      @(negedge CLK);
      RD = 0;
      chk(n, e, RDATA);
   endtask
   task automatic wait_irq(input int m, output int n);
      n = 0;
      while ((m ? CONV_DONE_IRQ1 : CONV_DONE_IRQ0) !== 1'b1 && n < 3000)
      begin
         @(negedge CLK);
         n++;
      end
      // A wait that runs out shows here as a missing request
      chk("irq wait", 8'h01,
         8'(m ? CONV_DONE_IRQ1 : CONV_DONE_IRQ0));
   endtask
   task automatic pin;
      @(negedge CLK) EXT_TRIGGER_PIN_N = 0;
      @(negedge CLK) EXT_TRIGGER_PIN_N = 1;
   endtask
   // Single mode on input 1, slow then fast
   task automatic t_single;
      wr(5'h10, 8'h61);
      wait_irq(0, n_slow);
      chk("chan0", 8'h01, 8'(CHAN0));
      rdchk(5'h10, 8'hc1, "csr0 end");
      wr(5'h10, 8'hc1);
      chk("irq keep", 8'h01, 8'(CONV_DONE_IRQ0));
      rdchk(5'h02, 8'h56, "res hi");
      rdchk(5'h03, 8'h80, "res lo");
      wr(5'h10, 8'h41);
      chk("irq clr", 8'h00, 8'(CONV_DONE_IRQ0));
      wr(5'h10, 8'h69);
      wait_irq(0, n_fast);
      chk("speed gap", 8'h84, 8'(n_slow - n_fast));
      @(negedge CLK) XFER_ACC0 = 1;
      @(negedge CLK) XFER_ACC0 = 0;
      chk("irq xfer", 8'h00, 8'(CONV_DONE_IRQ0));
   endtask
   // Scan of all four inputs of module 1, then stop
   task automatic t_scan;
      logic [9:0] v;
      wr(5'h11, 8'h73);
      wait_irq(1, n_slow);
      chk("chan1 wrap", 8'h00, 8'(CHAN1));
      rdchk(5'h11, 8'hf3, "scan run");
      @(negedge CLK) XFER_ACC1 = 1;
      @(negedge CLK) XFER_ACC1 = 0;
      chk("irq1 xfer", 8'h00, 8'(CONV_DONE_IRQ1));
      for (int i = 0; i < 4; i++)
      begin
         v = {2'(i), 8'ha6};
         rdchk(5'(8 + 2 * i), v[9:2], "scan hi");
         rdchk(5'(9 + 2 * i), {v[1:0], 6'h00}, "scan lo");
      end
      wr(5'h11, 8'h10);
      rdchk(5'h11, 8'h10, "scan stop");
   endtask
   // Shared triggers, abort, then standby
   task automatic t_trig;
      wr(5'h10, 8'h02);
      pin;
      rdchk(5'h10, 8'h02, "trig off");
      wr(5'h13, 8'hff);
      pin;
      rdchk(5'h10, 8'h22, "pin start");
      rdchk(5'h11, 8'h30, "pin start1");
      wr(5'h10, 8'h02);
      rdchk(5'h10, 8'h02, "abort");
      @(negedge CLK) TIMER_UNIT_TRIGGER = 1;
      @(negedge CLK) TIMER_UNIT_TRIGGER = 0;
      rdchk(5'h10, 8'h22, "timer start");
      @(negedge CLK) STANDBY = 1;
      @(negedge CLK) STANDBY = 0;
      rdchk(5'h13, 8'h7f, "trg reset");
      rdchk(5'h11, 8'h00, "csr reset");
      rdchk(5'h08, 8'h00, "res reset");
   endtask
   initial
   begin
      repeat (8) @(negedge CLK);
      RST = 0;
      t_single;
      t_scan;
      t_trig;
      conclude;
   end
   // Hang guard, far beyond the under two thousand cycles needed
   always @(posedge CLK)
   begin
      cyc <= cyc + 1;
      if (cyc == 20000)
      begin
         fails = fails + 1;
         conclude;
      end
   end
endmodule
